// [shared/ieg_map.vh]
`ifndef IEG_MAP_VH
`define IEG_MAP_VH
// Register addresses
`define IEG_ADDR_CFG      8'h30
`define IEG_ADDR_SRC      8'h31
`define IEG_ADDR_THS      8'h32
`define IEG_ADDR_DUR      8'h33
// Configuration fields
`define IEG_CFG_AOI       7
`define IEG_CFG_SIXD      6
// Source fields
`define IEG_SRC_ACTIVE    6
// Reset values
`define IEG_RST_BYTE      8'h00
`define IEG_RST_EN        6'h00
`define IEG_RST_FIELD     7'h00
`define IEG_RST_CNT       7'h00
// Mode codes {and_or_select, six_direction_enable}
`define IEG_MODE_OR       2'b00
`define IEG_MODE_MOVE     2'b01
`define IEG_MODE_AND      2'b10
`define IEG_MODE_POS      2'b11
// X/Y-axis enable mask used for four-direction detection
`define IEG_XY_MASK       6'h0f
// Duration counter saturation value
`define IEG_CNT_MAX       7'h7f
// Register select bit positions
`define IEG_SEL_CFG       0
`define IEG_SEL_SRC       1
`define IEG_SEL_THS       2
`define IEG_SEL_DUR       3
`endif

// [core/ieg_axis_cmp.v]
`default_nettype none
// Compares one signed axis sample against the threshold magnitude
module ieg_axis_cmp #(
    parameter DW = 8
) (
    // Sample and threshold
    input  wire signed [DW-1:0] sample,
    input  wire        [6:0]    threshold_value,
    // Results
    output wire                 high_cond,
    output wire                 low_cond
);
    wire signed [DW:0] thr;
    assign thr = {{(DW-6){1'b0}}, threshold_value};
    // Magnitude compare: high above +thr, low below -thr
    assign high_cond = ($signed({sample[DW-1], sample}) > thr);
    assign low_cond  = ($signed({sample[DW-1], sample}) < -thr);
endmodule // ieg_axis_cmp
`default_nettype wire

// [core/ieg_event_gen.v]
`include "ieg_map.vh"
`default_nettype none
module ieg_event_gen #(
    parameter DW        = 8,
    parameter BOOT_CYC  = 16
) (
    // Clock and reset
    input  wire                 clk,
    input  wire                 rst,
    // Register port
    input  wire [7:0]           reg_addr,
    input  wire                 reg_wr,
    input  wire [7:0]           reg_wdata,
    input  wire                 reg_rd,
    output reg  [7:0]           reg_rdata,
    // Sample stream, one strobe per sample period
    input  wire                 sample_rate_period,
    input  wire signed [DW-1:0] x_sample,
    input  wire signed [DW-1:0] y_sample,
    input  wire signed [DW-1:0] z_sample,
    // Control inputs
    input  wire                 latch_request_option,
    input  wire                 four_direction_option,
    input  wire                 irq_polarity,
    // Status
    output reg                  boot_done,
    output reg                  first_irq_pin
);
    reg  [7:0] cfg_q;
    reg  [6:0] ths_q;
    reg  [6:0] dur_q;
    reg  [6:0] cnt_q;
    reg  [5:0] src_q;
    reg        act_q;
    reg        known_q;
    reg  [7:0] boot_cnt_q;
    wire [5:0] cond;
    wire [5:0] en;
    wire [5:0] en_eff;
    wire [1:0] mode;
    wire       sixd;
    wire       hit;
    wire       known;
    wire       qual;
    wire       fire;
    wire       src_read;
    wire [3:0] sel;
    reg  [7:0] rd_mux;

    // One-hot register select, shared by the write and read-clear paths
    function [3:0] reg_sel;
        input [7:0] addr;
        begin
            case (addr)
                `IEG_ADDR_CFG: reg_sel = 4'h1;
                `IEG_ADDR_SRC: reg_sel = 4'h2;
                `IEG_ADDR_THS: reg_sel = 4'h4;
                `IEG_ADDR_DUR: reg_sel = 4'h8;
                default:       reg_sel = 4'h0;
            endcase
        end
    endfunction

    // Boot: configuration held at its stored default until boot completes
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            boot_cnt_q <= `IEG_RST_BYTE;
            boot_done  <= 1'b0;
        end
        else if (!boot_done)
        begin
            boot_cnt_q <= boot_cnt_q + 8'h01;
            boot_done  <= (boot_cnt_q == BOOT_CYC[7:0] - 8'h01);
        end
    end

    // Comparators see live samples; only the strobe cycle counts
    // Per-axis comparators, order XL XH YL YH ZL ZH from bit 0
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : g_axis
            wire signed [DW-1:0] s;
            assign s = (g == 0) ? x_sample : (g == 1) ? y_sample : z_sample;
            ieg_axis_cmp #(.DW(DW)) u_cmp (
                .sample          (s),
                .threshold_value (ths_q),
                .high_cond       (cond[2*g+1]),
                .low_cond        (cond[2*g])
            );
        end
    endgenerate

    // Enables gate both threshold events and direction zones
    assign en   = cfg_q[5:0];
    assign mode = {cfg_q[`IEG_CFG_AOI], cfg_q[`IEG_CFG_SIXD]};
    assign sixd = cfg_q[`IEG_CFG_SIXD];
    // Four-direction drops the Z pair only in six-direction modes
    assign en_eff = (sixd && four_direction_option) ? (en & `IEG_XY_MASK) : en;
    assign known  = |(cond & en_eff);
    // AND with no enables never fires, so an empty mask stays quiet
    assign hit = (mode == `IEG_MODE_AND) ? ((|en_eff) && ((cond & en_eff) == en_eff))
                                         : known;
    assign qual = hit && (cnt_q >= dur_q);
    assign fire = (mode == `IEG_MODE_MOVE) ? (qual && !known_q) : qual;
    assign sel      = reg_sel(reg_addr);
    assign src_read = reg_rd && sel[`IEG_SEL_SRC];

    // Duration counter and zone memory, stepped per sample
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_q   <= `IEG_RST_CNT;
            known_q <= 1'b0;
        end
        else if (sample_rate_period)
        begin
            // Zone memory lets movement fire on entry only
            known_q <= qual;
            if (!hit)
                cnt_q <= `IEG_RST_CNT;
            // Saturate so a long event never wraps back under the duration
            else if (cnt_q != `IEG_CNT_MAX)
                cnt_q <= cnt_q + 7'h01;
        end
    end

    // Configuration registers
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cfg_q <= `IEG_RST_BYTE;
            ths_q <= `IEG_RST_FIELD;
            dur_q <= `IEG_RST_FIELD;
        end
        // Writes before boot are dropped while stored defaults still load
        else if (reg_wr && boot_done)
        begin
            if (sel[`IEG_SEL_CFG])
                cfg_q <= reg_wdata;
            if (sel[`IEG_SEL_THS])
                ths_q <= reg_wdata[6:0];
            if (sel[`IEG_SEL_DUR])
                dur_q <= reg_wdata[6:0];
        end
    end

    // Source register; a set in the read cycle wins over the clear
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            src_q <= `IEG_RST_EN;
            act_q <= 1'b0;
        end
        else if (sample_rate_period)
        begin
            // Latched flags freeze until the host reads them
            if (latch_request_option && act_q && !src_read)
                src_q <= src_q;
            else
            begin
                src_q <= cond & en_eff;
                act_q <= fire;
            end
        end
        else if (src_read)
            act_q <= 1'b0;
    end

    // Read mux; unmapped addresses read zero
    always @*
    begin
        case (reg_addr)
            `IEG_ADDR_CFG: rd_mux = cfg_q;
            `IEG_ADDR_SRC: rd_mux = {1'b0, act_q, src_q};
            `IEG_ADDR_THS: rd_mux = {1'b0, ths_q};
            `IEG_ADDR_DUR: rd_mux = {1'b0, dur_q};
            default:       rd_mux = `IEG_RST_BYTE;
        endcase
    end

    // Registered outputs; a read clears the pin one cycle after the strobe
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            reg_rdata     <= `IEG_RST_BYTE;
            first_irq_pin <= 1'b0;
        end
        else
        begin
            reg_rdata     <= rd_mux;
            first_irq_pin <= (act_q && !src_read) ^ irq_polarity;
        end
    end
endmodule // ieg_event_gen
`default_nettype wire

// [verification/ieg_host.sv]
`default_nettype none
module ieg_host (
    // Register port
    input  wire logic       clk,
    output var  logic [7:0] reg_addr,
    output var  logic       reg_wr,
    output var  logic [7:0] reg_wdata,
    output var  logic       reg_rd,
    input  wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {reg_addr, reg_wr, reg_wdata, reg_rd} = 18'h0_0000;
    // Released data shows the inverse, never a stale copy
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk) {reg_addr, reg_wdata, reg_wr} = {a, v, 1'b1};
        @(negedge clk) {reg_wdata, reg_wr} = {~v, 1'b0};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge clk) {reg_addr, reg_rd} = {a, 1'b1};
        @(negedge clk) reg_rd = 1'b0;
        v = reg_rdata;
    endtask
endmodule // ieg_host
`default_nettype wire

// [verification/ieg_chk_asserts.sv]
`default_nettype none
module ieg_chk #(
    parameter int BOOT_CYC = 16
) (
    // Ports watched
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       sample_rate_period,
    input wire logic       irq_polarity,
    input wire logic       boot_done,
    input wire logic       first_irq_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cfg_q, n_q;
    wire        rs = reg_rd && reg_addr == 8'h31;
    always_ff @(posedge clk or posedge rst) n_q <= rst ? 8'h00 : n_q + {7'h00, n_q != 8'hff};
    // Shadow only takes writes after boot
    always_ff @(posedge clk or posedge rst)
        cfg_q <= rst ? 8'h00 : reg_wr && boot_done && reg_addr == 8'h30 ? reg_wdata : cfg_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_SRC_TOP: assert property (rs |=> !reg_rdata[7]) else $error("src top");
    AST_CFG_RB: assert property (reg_rd && reg_addr == 8'h30 |=> reg_rdata == cfg_q)
        else $error("cfg readback");
    AST_THS_TOP: assert property (reg_rd && reg_addr == 8'h32 |=> !reg_rdata[7])
        else $error("ths top");
    AST_DUR_TOP: assert property (reg_rd && reg_addr == 8'h33 |=> !reg_rdata[7])
        else $error("dur top");
    AST_READ_CLR: assert property (rs && !sample_rate_period && !$past(sample_rate_period)
        && $stable(irq_polarity) |=> first_irq_pin == $past(irq_polarity))
        else $error("read clr");
    AST_PIN_CAUSE: assert property (!$stable(first_irq_pin) |-> $past(sample_rate_period, 2)
        || $past(sample_rate_period) || $past(reg_rd) || $past(reg_wr)
        || $past(irq_polarity) != $past(irq_polarity, 2) || !$stable(irq_polarity))
        else $error("pin cause");
    AST_POL_IDLE: assert property (!boot_done && $stable(irq_polarity)
        |=> first_irq_pin == $past(irq_polarity)) else $error("pin idle");
    AST_BOOT: assert property (n_q + 1 < BOOT_CYC ? !boot_done : n_q <= BOOT_CYC || boot_done)
        else $error("boot time");
endmodule // ieg_chk
bind ieg_event_gen ieg_chk #(.BOOT_CYC(BOOT_CYC)) u_chk (.*);
`default_nettype wire

// [verification/tb_inertial_event_interrupt_gen.sv]
`default_nettype none
module tb_inertial_event_interrupt_gen;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, rst = 1'b1, sample_rate_period = 1'b0, irq_polarity = 1'b0;
    logic        latch_request_option = 1'b0, four_direction_option = 1'b0;
    logic        reg_wr, reg_rd, boot_done, first_irq_pin;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, d, x_sample = 8'h00, y_sample, z_sample;
    int          mismatches = 0, samples_checked = 0, i;
    // Config, x, y, z, expected source byte; threshold 16
    logic [39:0] rows [8] = '{40'h02_2000_0042, 40'h01_e000_0041, 40'h30_0000_1000,
        40'h42_2000_0042, 40'h30_0000_1160, 40'h8a_2005_0002, 40'h8a_2020_004a, 40'hc2_2000_0042};
    // X sample, expected pin: duration two with a lapse, then movement entry
    logic [15:0] pseq [10] = '{16'h0000, 16'h2000, 16'h2000, 16'h0000, 16'h2000, 16'h2000,
        16'h2001, 16'h0000, 16'h2001, 16'h2000};
    always #2.5 clk = ~clk;
    ieg_host host (.*);
    ieg_event_gen uut (.*);
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        samples_checked++;
        if (s !== e)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic finish_test();
        $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic smp(input logic [23:0] v);
        @(negedge clk) {sample_rate_period, x_sample, y_sample, z_sample} = {1'b1, v};
        @(negedge clk) {sample_rate_period, x_sample, y_sample, z_sample} = {1'b0, ~v};
        repeat (2) @(negedge clk);
    endtask
    initial
    begin
        {y_sample, z_sample} = 16'h0000;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        host.wr(8'h30, 8'hff);
        irq_polarity = 1'b1;
        @(negedge clk);
        chk({7'h00, first_irq_pin}, 8'h01);
        irq_polarity = 1'b0;
        for (i = 0; i < 40 && boot_done !== 1'b1; i++) @(negedge clk);
        chk({7'h00, boot_done}, 8'h01);
        if (boot_done !== 1'b1) finish_test();
        for (i = 0; i < 5; i++)
        begin
            host.rd(i == 4 ? 8'h40 : 8'h30 | i[7:0], d);
            chk(d, 8'h00);
        end
        host.wr(8'h32, 8'h90);
        host.rd(8'h32, d);
        chk(d, 8'h10);
        for (i = 0; i < 8; i++)
        begin
            host.wr(8'h30, rows[i][39:32]);
            smp(rows[i][31:8]);
            chk({7'h00, first_irq_pin}, {7'h00, rows[i][6]});
            host.rd(8'h31, d);
            chk(d, rows[i][7:0]);
        end
        host.wr(8'h33, 8'h82);
        host.wr(8'h30, 8'h02);
        for (i = 0; i < 10; i++)
        begin
            if (i == 7) host.wr(8'h33, 8'h00);
            if (i == 7) host.wr(8'h30, 8'h42);
            smp({pseq[i][15:8], 16'h0000});
            chk({7'h00, first_irq_pin}, pseq[i][7:0]);
        end
        host.wr(8'h30, 8'h02);
        latch_request_option = 1'b1;
        smp(24'h20_0000);
        smp(24'h00_0000);
        chk({7'h00, first_irq_pin}, 8'h01);
        host.rd(8'h31, d);
        chk(d, 8'h42);
        chk({7'h00, first_irq_pin}, 8'h00);
        smp(24'h00_0000);
        host.rd(8'h31, d);
        chk(d, 8'h00);
        // Four-direction drops the Z pair in position mode
        latch_request_option = 1'b0;
        four_direction_option = 1'b1;
        host.wr(8'h30, 8'he0);
        smp(24'h00_0020);
        host.rd(8'h31, d);
        chk(d, 8'h00);
        four_direction_option = 1'b0;
        smp(24'h00_0020);
        chk({7'h00, first_irq_pin}, 8'h01);
        host.rd(8'h31, d);
        chk(d, 8'h60);
        // Reset in mid-run brings back the boot defaults
        @(negedge clk) rst = 1'b1;
        repeat (2) @(negedge clk);
        chk({6'h00, boot_done, first_irq_pin}, 8'h00);
        rst = 1'b0;
        for (i = 0; i < 40 && boot_done !== 1'b1; i++) @(negedge clk);
        chk({7'h00, boot_done}, 8'h01);
        host.rd(8'h30, d);
        chk(d, 8'h00);
        finish_test();
    end
endmodule // tb_inertial_event_interrupt_gen
`default_nettype wire
